// file: dv/pin_partner.sv
// Partner model of the primary pin: a pulse source or a load.
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
	input  wire logic mclk,
	input  wire logic pin_oe,
	input  wire logic pin_out,
	output logic      pin_in
);
	logic src = 1'b0;
	// A driven pin reads back its own level; a released one sees the source.
	assign pin_in = pin_oe ? pin_out : src;
	task automatic edges(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge mclk);
			src <= ~src;
		end
	endtask
endmodule
`default_nettype wire

// file: dv/reload_timer_pulse_event_test.sv
// Self-checking bench for the reload timer.
`timescale 1ns/1ns
`default_nettype none
module reload_timer_pulse_event_test;
	localparam logic [11:0] ctl = reload_timer_pkg::idx_timer_control,
		io  = reload_timer_pkg::idx_timer_io_control,
		md  = reload_timer_pkg::idx_timer_mode,
		pre = reload_timer_pkg::idx_prescaler,
		mc  = reload_timer_pkg::idx_main_counter,
		st  = reload_timer_pkg::idx_int_status,
		mk  = reload_timer_pkg::idx_int_mask;
	logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [13:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr, pin_in, pin_out, pin_oe;
	logic        comp_out, comp_oe, irq, lv;
	logic [32:0] exp_q[$];
	int          err_total = 0, num_checks = 0, seed = 32'h683c74a9;
	int          n, m, t;

	always #25 mclk = ~mclk;

	reload_timer_pulse_event u_dut (.mclk(mclk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pulse_pin_in(pin_in), .pulse_pin_out(pin_out),
		.pulse_pin_oe(pin_oe), .companion_pin_out(comp_out),
		.companion_pin_oe(comp_oe), .irq(irq));
	pin_partner u_src (.mclk(mclk), .pin_oe(pin_oe), .pin_out(pin_out),
		.pin_in(pin_in));

	task automatic check(input string what, input logic [32:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Expected read results are queued here as {pslverr, prdata}.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e = '0);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	always @(posedge mclk)
		if (psel && penable && pready && !pwrite)
			check("read", {pslverr, prdata}, exp_q.pop_front());

	// The pin is read before each edge's updates, so t counts one period.
	task automatic wait_toggle;
		lv = pin_out;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (pin_out === lv && t < 200);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		apb(0, io, 0, 0);
		check("reset level", pin_out, 1);
		apb(0, 12'h000, 0, 33'h1_0000_0000);
		$display("reset test done");
		n = $random(seed) & 3;
		m = $random(seed) & 3;
		apb(1, pre, n);
		apb(1, mc, m);
		apb(1, io, 1);
		check("start low", pin_out, 0);
		apb(1, io, 0);
		check("start high", pin_out, 1);
		apb(1, mk, 1);
		apb(1, ctl, 1);
		wait_toggle();
		wait_toggle();
		check("period", t, (n + 1) * (m + 1));
		check("irq", irq, 1);
		apb(1, io, 6);
		check("pin oe", pin_oe, 0);
		check("comp oe", comp_oe, 1);
		check("comp", comp_out, !pin_out);
		apb(1, ctl, 0);
		apb(0, st, 0, 1);
		apb(1, mk, 0);
		check("masked", irq, 0);
		apb(1, st, 1);
		apb(0, st, 0, 0);
		$display("pulse test done");
		apb(1, md, 1);
		apb(1, io, 0);
		apb(1, pre, 0);
		apb(1, mc, 5);
		apb(1, ctl, 1);
		apb(0, ctl, 0, 3);
		u_src.edges(4, 1);
		repeat (4) @(posedge mclk);
		apb(1, ctl, 4);
		apb(0, ctl, 0, 0);
		u_src.edges(4, 3);
		repeat (4) @(posedge mclk);
		apb(0, mc, 0, 3);
		apb(1, io, 1);
		apb(1, ctl, 1);
		u_src.edges(2, 2);
		repeat (4) @(posedge mclk);
		apb(1, ctl, 0);
		apb(0, mc, 0, 2);
		$display("event test done");
		report_and_stop();
	end

	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// file: hw/reload_timer_pkg.sv
// Package of register map, field positions and reset values for the timer.
package reload_timer_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [11:0] idx_timer_control    = 12'h100;
	localparam logic [11:0] idx_timer_io_control = 12'h101;
	localparam logic [11:0] idx_timer_mode       = 12'h102;
	localparam logic [11:0] idx_prescaler        = 12'h103;
	localparam logic [11:0] idx_main_counter     = 12'h104;
	localparam logic [11:0] idx_int_status       = 12'h105;
	localparam logic [11:0] idx_int_mask         = 12'h106;

	// Fields of timer_control.
	localparam int count_start_pos = 0;
	localparam int count_busy_pos  = 1;
	localparam int forced_stop_pos = 2;

	// Fields of timer_io_control.
	localparam int polarity_select_pos          = 0;
	localparam int primary_output_disable_pos   = 1;
	localparam int companion_output_enable_pos  = 2;

	// Field of timer_mode.
	localparam int event_mode_pos = 0;

	// Field of int_status and int_mask.
	localparam int underflow_pos = 0;

	localparam logic [7:0] io_control_reset = 8'h00;
	localparam logic [7:0] counter_reset    = 8'hff;
	localparam logic [7:0] zero_byte        = 8'h00;

	typedef enum logic {
		mode_pulse_output,
		mode_event_counter
	} timer_mode_e;

endpackage

// file: hw/reload_timer_pulse_event.sv
// Prescaled reload down-counter with pulse output and event counting.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module reload_timer_pulse_event (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [13:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pulse_pin_in,
	output logic             pulse_pin_out,
	output logic             pulse_pin_oe,
	output logic             companion_pin_out,
	output logic             companion_pin_oe,
	output logic             irq
);

	logic [7:0]  timer_io_control;
	logic        running;
	logic        event_mode;
	logic [7:0]  prescaler_reload;
	logic [7:0]  prescaler_counter;
	logic [7:0]  main_reload;
	logic [7:0]  main_counter;
	logic        int_status;
	logic        int_mask;
	logic        pulse_level;
	logic        pin_prev;
	logic [31:0] next_prdata;

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	// Bus decode.
	wire        setup_phase = psel && !penable;
	wire        wr_en       = psel && penable && pwrite;
	wire [11:0] reg_idx     = paddr[13:2];
	wire        word_ok     = (paddr[1:0] == 2'b00);
	wire        hit_ctrl    = word_ok &&
		(reg_idx == reload_timer_pkg::idx_timer_control);
	wire        hit_ioc     = word_ok &&
		(reg_idx == reload_timer_pkg::idx_timer_io_control);
	wire        hit_mode    = word_ok &&
		(reg_idx == reload_timer_pkg::idx_timer_mode);
	wire        hit_pre     = word_ok &&
		(reg_idx == reload_timer_pkg::idx_prescaler);
	wire        hit_main    = word_ok &&
		(reg_idx == reload_timer_pkg::idx_main_counter);
	wire        hit_stat    = word_ok &&
		(reg_idx == reload_timer_pkg::idx_int_status);
	wire        hit_mask    = word_ok &&
		(reg_idx == reload_timer_pkg::idx_int_mask);
	wire        hit_any     = hit_ctrl || hit_ioc || hit_mode || hit_pre ||
		hit_main || hit_stat || hit_mask;

	wire wr_ctrl = wr_en && hit_ctrl;
	wire wr_ioc  = wr_en && hit_ioc;
	wire wr_mode = wr_en && hit_mode;
	wire wr_pre  = wr_en && hit_pre;
	wire wr_main = wr_en && hit_main;
	wire wr_stat = wr_en && hit_stat;
	wire wr_mask = wr_en && hit_mask;

	wire start_wr = pwdata[reload_timer_pkg::count_start_pos];
	wire stop_wr  = pwdata[reload_timer_pkg::forced_stop_pos];

	// Control fields.
	wire polarity_select = timer_io_control[reload_timer_pkg::polarity_select_pos];
	wire primary_output_disable =
		timer_io_control[reload_timer_pkg::primary_output_disable_pos];
	wire companion_output_enable =
		timer_io_control[reload_timer_pkg::companion_output_enable_pos];

	// Count source: every clock in pulse mode, the chosen pin edge otherwise.
	wire rise_seen  = pulse_pin_in && !pin_prev;
	wire fall_seen  = !pulse_pin_in && pin_prev;
	wire edge_hit   = polarity_select ? fall_seen : rise_seen;
	wire count_src  = event_mode ? edge_hit : 1'b1;
	wire count_tick = running && count_src;

	// The main counter steps only when the prescaler wraps.
	wire pre_wrap   = count_tick && (prescaler_counter == reload_timer_pkg::zero_byte);
	wire underflow  = pre_wrap && (main_counter == reload_timer_pkg::zero_byte);

	// The start level is (re)applied on every write to the pin setup or mode register.
	wire level_load = wr_ioc || wr_mode;
	wire load_level = !pwdata[reload_timer_pkg::polarity_select_pos];

	// Read mux.
	wire [31:0] rd_ctrl = {29'h0000000, 1'b0, running, running};
	wire [31:0] rd_ioc  = {24'h000000, timer_io_control};
	wire [31:0] rd_mode = {31'h00000000, event_mode};
	wire [31:0] rd_pre  = {24'h000000, prescaler_counter};
	wire [31:0] rd_main = {24'h000000, main_counter};
	wire [31:0] rd_stat = {31'h00000000, int_status};
	wire [31:0] rd_mask = {31'h00000000, int_mask};

	always_comb begin
		if (hit_ctrl) begin
			next_prdata = rd_ctrl;
		end else if (hit_ioc) begin
			next_prdata = rd_ioc;
		end else if (hit_mode) begin
			next_prdata = rd_mode;
		end else if (hit_pre) begin
			next_prdata = rd_pre;
		end else if (hit_main) begin
			next_prdata = rd_main;
		end else if (hit_stat) begin
			next_prdata = rd_stat;
		end else if (hit_mask) begin
			next_prdata = rd_mask;
		end else begin
			next_prdata = 32'h00000000;
		end
	end

	// Read data and error are caught at the setup edge, answered next cycle.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= pwrite ? 32'h00000000 : next_prdata;
			pslverr <= !hit_any;
		end
	end

	assign pready = 1'b1;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			timer_io_control <= reload_timer_pkg::io_control_reset;
			event_mode       <= 1'b0;
			int_mask         <= 1'b0;
		end else begin
			if (wr_ioc) begin
				timer_io_control <= pwdata[7:0];
			end
			if (wr_mode) begin
				event_mode <= pwdata[reload_timer_pkg::event_mode_pos];
			end
			if (wr_mask) begin
				int_mask <= pwdata[reload_timer_pkg::underflow_pos];
			end
		end
	end

	// Start and stop; forced stop wins over a start in the same write.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			running <= 1'b0;
		end else if (wr_ctrl) begin
			running <= start_wr && !stop_wr;
		end
	end

	// Prescaler and main counter; a write loads reload and counter together.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prescaler_reload  <= reload_timer_pkg::counter_reset;
			prescaler_counter <= reload_timer_pkg::counter_reset;
			main_reload       <= reload_timer_pkg::counter_reset;
			main_counter      <= reload_timer_pkg::counter_reset;
		end else begin
			if (wr_pre) begin
				prescaler_reload  <= pwdata[7:0];
				prescaler_counter <= pwdata[7:0];
			end else if (pre_wrap) begin
				prescaler_counter <= prescaler_reload;
			end else if (count_tick) begin
				prescaler_counter <= prescaler_counter - 8'h01;
			end
			if (wr_main) begin
				main_reload  <= pwdata[7:0];
				main_counter <= pwdata[7:0];
			end else if (underflow) begin
				main_counter <= main_reload;
			end else if (pre_wrap) begin
				main_counter <= main_counter - 8'h01;
			end
		end
	end

	// Sticky underflow flag; a new underflow beats a write-one clear.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			int_status <= 1'b0;
		end else if (underflow) begin
			int_status <= 1'b1;
		end else if (wr_stat && pwdata[reload_timer_pkg::underflow_pos]) begin
			int_status <= 1'b0;
		end
	end

	assign irq = int_status && int_mask;

	// Output level and previous pin sample for edge detection.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pulse_level <= 1'b1;
			pin_prev    <= 1'b0;
		end else begin
			pin_prev <= pulse_pin_in;
			if (level_load) begin
				pulse_level <= wr_ioc ? load_level : !polarity_select;
			end else if (underflow) begin
				pulse_level <= !pulse_level;
			end
		end
	end

	assign pulse_pin_out     = pulse_level;
	assign pulse_pin_oe      = !event_mode && !primary_output_disable;
	assign companion_pin_out = !pulse_level;
	assign companion_pin_oe  = companion_output_enable;

	a_start_level: assert property (
		wr_ioc |=> pulse_level == !$past(pwdata[0]))
		else $error("pulse start level does not follow polarity bit");

	a_primary_gate: assert property (
		primary_output_disable |-> !pulse_pin_oe)
		else $error("primary pin driven while disabled");

	a_companion_inverse: assert property (
		companion_pin_oe |-> companion_pin_out != pulse_pin_out)
		else $error("companion pin is not the inverse of the pulse");

	a_event_source: assert property (
		event_mode && !edge_hit && !wr_pre |=> $stable(prescaler_counter))
		else $error("prescaler moved without a pin edge");

	a_edge_select: assert property (
		event_mode && running && !polarity_select && !pin_prev
		&& pulse_pin_in && !wr_pre && !wr_ctrl
		|=> prescaler_counter ==
		(($past(prescaler_counter) == reload_timer_pkg::zero_byte) ?
		$past(prescaler_reload) : $past(prescaler_counter) - 8'h01))
		else $error("rising edge not counted");

	a_reload_underflow: assert property (
		underflow && !wr_main |=> main_counter == $past(main_reload))
		else $error("main counter did not reload at underflow");

	a_prescale_cascade: assert property (
		count_tick && !pre_wrap && !wr_main |=> $stable(main_counter))
		else $error("main counter stepped before prescaler wrap");

	a_count_start: assert property (
		wr_ctrl && start_wr && !stop_wr |=> running)
		else $error("counting did not start");

	a_count_stop: assert property (
		wr_ctrl && (stop_wr || !start_wr) |=> !running ##1 !running || wr_ctrl)
		else $error("counting did not stop");

	a_irq_underflow: assert property (
		underflow |=> int_status)
		else $error("underflow did not set the status flag");

	a_pulse_toggle: assert property (
		underflow && !level_load |=> pulse_level != $past(pulse_level))
		else $error("pulse did not toggle at underflow");

	// A reload of zero leaves the prescaler at zero, so the step is
	// checked against the reload value rather than as a plain change.
	a_edge_falling: assert property (
		event_mode && running && polarity_select && pin_prev
		&& !pulse_pin_in && !wr_pre && !wr_ctrl
		|=> prescaler_counter ==
		(($past(prescaler_counter) == reload_timer_pkg::zero_byte) ?
		$past(prescaler_reload) : $past(prescaler_counter) - 8'h01))
		else $error("falling edge not counted");

	a_companion_gate: assert property (
		!companion_output_enable |-> !companion_pin_oe)
		else $error("companion pin driven while disabled");

	a_event_input: assert property (
		event_mode |-> !pulse_pin_oe)
		else $error("primary pin driven in event counter mode");

	a_prescale_step: assert property (
		count_tick && !wr_pre
		&& prescaler_counter != reload_timer_pkg::zero_byte
		|=> prescaler_counter == $past(prescaler_counter) - 8'h01)
		else $error("prescaler did not decrement on a count event");

	a_prescale_reload: assert property (
		pre_wrap && !wr_pre |=> prescaler_counter == $past(prescaler_reload))
		else $error("prescaler did not reload at wrap");

	a_main_step: assert property (
		pre_wrap && !underflow && !wr_main
		|=> main_counter == $past(main_counter) - 8'h01)
		else $error("main counter did not step at prescaler wrap");

	a_stopped_prescaler: assert property (
		!running && !wr_pre |=> $stable(prescaler_counter))
		else $error("prescaler moved while stopped");

	a_stopped_main: assert property (
		!running && !wr_main |=> $stable(main_counter))
		else $error("main counter moved while stopped");

	a_forced_stop: assert property (
		wr_ctrl && stop_wr |=> !running)
		else $error("forced stop did not halt counting");

	a_start_hold: assert property (
		!wr_ctrl |=> $stable(running))
		else $error("run state changed without a control write");

	a_status_clear: assert property (
		wr_stat && pwdata[reload_timer_pkg::underflow_pos] && !underflow
		|=> !int_status)
		else $error("write one did not clear the status flag");

	a_level_hold: assert property (
		!underflow && !level_load |=> $stable(pulse_level))
		else $error("pulse level changed without underflow");

	a_bus_error: assert property (
		setup_phase && !hit_any |=> pslverr)
		else $error("unmapped access not flagged");

	a_write_no_data: assert property (
		setup_phase && pwrite |=> prdata == 32'h00000000)
		else $error("read data not zero on a write");

endmodule

`default_nettype wire
